// ---- design/usb_hub_port_swap_remap_cfg.sv ----
// Purpose: DP/DM pin-role swap and physical-to-logical remap of ports 1-2
// Assumes: config port and attach request come from logic on MCLK
// Notes:   pad inputs are synchronised, every output is a flip-flop
//
// Operation
// RQ1: swap bit clear keeps D+ on DP pin and D- on DM pin.
// RQ2: swap bit set carries D+ on DM pin and D- on DP pin.
// RQ3: mask bit zero swaps the upstream port only.
// RQ4: mask bits one to seven swap their own downstream port independently.
// RQ5: remap fields act only while the remap enable bit is set.
// RQ6: hub reports a port count; host numbers run one up to it.
// RQ7: upper nibble gives port two logical number; zero disables it.
// RQ8: upper codes one to five map port two to logical one to five.
// RQ9: config source assigns logical numbers contiguously from one, no gaps.
// RQ10: lower nibble maps port one the same way, codes one to seven.
// RQ11: port two codes six, seven map there; codes eight up disable.
// RQ12: settings latch before attach and stay fixed while attached.

`timescale 1ns/1ns

module usb_hub_port_swap_remap_cfg (
   input  wire logic       MCLK,
   input  wire logic       RST_N,
   input  wire logic       CFG_WR,
   input  wire logic       CFG_RD,
   input  wire logic [7:0] CFG_ADDR,
   input  wire logic [7:0] CFG_WDATA,
   output logic      [7:0] CFG_RDATA,
   output logic            CFG_WR_REFUSED,
   input  wire logic       LOGICAL_REMAP_ENABLE,
   input  wire logic       ATTACH_REQ,
   output logic            ATTACH_LOCKED,
   input  wire logic [7:0] CORE_DPLUS_O,
   input  wire logic [7:0] CORE_DMINUS_O,
   input  wire logic [7:0] CORE_OE,
   output logic      [7:0] CORE_DPLUS_I,
   output logic      [7:0] CORE_DMINUS_I,
   input  wire logic [7:0] PAD_DP_I,
   input  wire logic [7:0] PAD_DM_I,
   output logic      [7:0] PAD_DP_O,
   output logic      [7:0] PAD_DM_O,
   output logic      [7:0] PAD_OE,
   output logic      [2:0] LOGICAL_P1,
   output logic      [2:0] LOGICAL_P2,
   output logic      [1:0] PORT_EN,
   output logic      [2:0] REPORTED_PORTS,
   input  wire logic [2:0] HOST_LPORT,
   output logic            LPORT_VALID,
   output logic      [1:0] LPORT_PHYS
);

   // ***********************************************************
   // configuration words and attach lock
   // ***********************************************************
   hub_cfg_pkg::lock_state_t lock_r;
   hub_cfg_pkg::lock_state_t lock_nxt;
   logic [7:0]               pin_role_swap_mask_r;
   logic [7:0]               remap_field_ports_one_two_r;
   logic [7:0]               swap_act_r;
   logic [7:0]               remap_act_r;
   logic                     logical_remap_enable_r;
   logic                     wr_open;

   always_comb begin
      case (lock_r)
         hub_cfg_pkg::ST_OPEN:
            lock_nxt = ATTACH_REQ ? hub_cfg_pkg::ST_LOCKED
                                  : hub_cfg_pkg::ST_OPEN;
         hub_cfg_pkg::ST_LOCKED:
            lock_nxt = ATTACH_REQ ? hub_cfg_pkg::ST_LOCKED
                                  : hub_cfg_pkg::ST_OPEN;
         default:
            lock_nxt = hub_cfg_pkg::ST_OPEN;
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         lock_r        <= hub_cfg_pkg::ST_OPEN;
         ATTACH_LOCKED <= 1'b0;
      end else begin
         lock_r        <= lock_nxt;
         ATTACH_LOCKED <= (lock_nxt == hub_cfg_pkg::ST_LOCKED);
      end
   end

   // writes while attached would move pins under live traffic
   assign wr_open = CFG_WR && (lock_r == hub_cfg_pkg::ST_OPEN);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_role_swap_mask_r        <= hub_cfg_pkg::SWAP_MASK_RST;
         remap_field_ports_one_two_r <= hub_cfg_pkg::REMAP12_RST;
         CFG_WR_REFUSED              <= 1'b0;
      end else begin
         if (wr_open && CFG_ADDR == hub_cfg_pkg::SWAP_MASK_OFS) begin
            pin_role_swap_mask_r <= CFG_WDATA;
         end
         if (wr_open && CFG_ADDR == hub_cfg_pkg::REMAP12_OFS) begin
            remap_field_ports_one_two_r <= CFG_WDATA;
         end
         CFG_WR_REFUSED <= CFG_WR && !wr_open; // [RQ12]
      end
   end

   // active copies follow the words only while detached
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         swap_act_r             <= hub_cfg_pkg::SWAP_MASK_RST;
         remap_act_r            <= hub_cfg_pkg::REMAP12_RST;
         logical_remap_enable_r <= 1'b0;
      end else if (lock_r == hub_cfg_pkg::ST_OPEN) begin // [RQ12]
         swap_act_r             <= pin_role_swap_mask_r;
         remap_act_r            <= remap_field_ports_one_two_r;
         logical_remap_enable_r <= LOGICAL_REMAP_ENABLE;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         CFG_RDATA <= hub_cfg_pkg::UNMAPPED_RDATA;
      end else if (CFG_RD) begin
         case (CFG_ADDR)
            hub_cfg_pkg::SWAP_MASK_OFS: CFG_RDATA <= pin_role_swap_mask_r;
            hub_cfg_pkg::REMAP12_OFS:
               CFG_RDATA <= remap_field_ports_one_two_r;
            default: CFG_RDATA <= hub_cfg_pkg::UNMAPPED_RDATA;
         endcase
      end
   end

   // ***********************************************************
   // pin-role swap
   // ***********************************************************
   logic [7:0] dp_m1_r;
   logic [7:0] dp_s_r;
   logic [7:0] dm_m1_r;
   logic [7:0] dm_s_r;
   logic [7:0] dp_o_nxt;
   logic [7:0] dm_o_nxt;
   logic [7:0] dplus_i_nxt;
   logic [7:0] dminus_i_nxt;

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         dp_m1_r <= 8'h00;
         dp_s_r  <= 8'h00;
         dm_m1_r <= 8'h00;
         dm_s_r  <= 8'h00;
      end else begin
         dp_m1_r <= PAD_DP_I;
         dp_s_r  <= dp_m1_r;
         dm_m1_r <= PAD_DM_I;
         dm_s_r  <= dm_m1_r;
      end
   end

   // bit 0 is upstream, bits 1..7 each follow their own port
   genvar gi;
   generate
      for (gi = 0; gi < hub_cfg_pkg::NUM_PAD_PORTS; gi++) begin : g_swap
         always_comb begin
            if (swap_act_r[gi]) begin // [RQ2] [RQ3] [RQ4]
               dp_o_nxt[gi]     = CORE_DMINUS_O[gi];
               dm_o_nxt[gi]     = CORE_DPLUS_O[gi];
               dplus_i_nxt[gi]  = dm_s_r[gi];
               dminus_i_nxt[gi] = dp_s_r[gi];
            end else begin // [RQ1]
               dp_o_nxt[gi]     = CORE_DPLUS_O[gi];
               dm_o_nxt[gi]     = CORE_DMINUS_O[gi];
               dplus_i_nxt[gi]  = dp_s_r[gi];
               dminus_i_nxt[gi] = dm_s_r[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         PAD_DP_O      <= 8'h00;
         PAD_DM_O      <= 8'h00;
         PAD_OE        <= 8'h00;
         CORE_DPLUS_I  <= 8'h00;
         CORE_DMINUS_I <= 8'h00;
      end else begin
         PAD_DP_O      <= dp_o_nxt;
         PAD_DM_O      <= dm_o_nxt;
         PAD_OE        <= CORE_OE;
         CORE_DPLUS_I  <= dplus_i_nxt;
         CORE_DMINUS_I <= dminus_i_nxt;
      end
   end

   // ***********************************************************
   // port remap and host numbering
   // ***********************************************************
   logic [2:0] lp1;
   logic [2:0] lp2;
   logic       en1;
   logic       en2;
   logic [2:0] count_nxt;

   port_map_decode u_map_p1 (
      .code     (remap_act_r[hub_cfg_pkg::P1_FIELD_LO +: 4]), // [RQ10]
      .remap_en (logical_remap_enable_r),
      .identity (hub_cfg_pkg::IDENT_P1),
      .lport    (lp1),
      .enabled  (en1)
   );

   port_map_decode u_map_p2 (
      .code     (remap_act_r[hub_cfg_pkg::P2_FIELD_LO +: 4]), // [RQ7] [RQ8]
      .remap_en (logical_remap_enable_r),
      .identity (hub_cfg_pkg::IDENT_P2),
      .lport    (lp2),
      .enabled  (en2)
   );

   // count is only a valid top number if numbering has no gaps [RQ9]
   assign count_nxt = {2'b00, en1} + {2'b00, en2};

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         LOGICAL_P1     <= hub_cfg_pkg::LPORT_NONE;
         LOGICAL_P2     <= hub_cfg_pkg::LPORT_NONE;
         PORT_EN        <= 2'h0;
         REPORTED_PORTS <= 3'h0;
         LPORT_VALID    <= 1'b0;
         LPORT_PHYS     <= 2'h0;
      end else begin
         LOGICAL_P1     <= lp1;
         LOGICAL_P2     <= lp2;
         PORT_EN        <= {en2, en1};
         REPORTED_PORTS <= count_nxt; // [RQ6]
         LPORT_VALID    <= (HOST_LPORT != hub_cfg_pkg::LPORT_NONE) &&
                           (HOST_LPORT <= count_nxt); // [RQ6]
         LPORT_PHYS     <= {en2 && (lp2 == HOST_LPORT),
                            en1 && (lp1 == HOST_LPORT)};
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   property p_straight;
      @(posedge MCLK) disable iff (!RST_N)
      1'b1 |=> ((PAD_DP_O ^ $past(CORE_DPLUS_O)) & ~$past(swap_act_r))
               == 8'h00;
   endproperty
   a_straight: assert property (p_straight) // [RQ1]
      else $error("unswapped DP pin does not carry D+");

   property p_crossed;
      @(posedge MCLK) disable iff (!RST_N)
      1'b1 |=> ((PAD_DM_O ^ $past(CORE_DPLUS_O)) & $past(swap_act_r))
               == 8'h00;
   endproperty
   a_crossed: assert property (p_crossed) // [RQ2]
      else $error("swapped DM pin does not carry D+");

   property p_upstream;
      @(posedge MCLK) disable iff (!RST_N)
      swap_act_r[0] |=> PAD_DP_O[0] == $past(CORE_DMINUS_O[0]);
   endproperty
   a_upstream: assert property (p_upstream) // [RQ3]
      else $error("upstream swap not applied");

   property p_rx_indep;
      @(posedge MCLK) disable iff (!RST_N)
      1'b1 |=> ((CORE_DPLUS_I ^ $past(dm_s_r)) & $past(swap_act_r)) == 8'h00
               && ((CORE_DPLUS_I ^ $past(dp_s_r)) & ~$past(swap_act_r))
               == 8'h00;
   endproperty
   a_rx_indep: assert property (p_rx_indep) // [RQ4]
      else $error("receive path does not follow its own swap bit");

   property p_no_remap;
      @(posedge MCLK) disable iff (!RST_N)
      !logical_remap_enable_r |=> LOGICAL_P1 == 3'h1 && LOGICAL_P2 == 3'h2;
   endproperty
   a_no_remap: assert property (p_no_remap) // [RQ5]
      else $error("remap fields acted while remap disabled");

   property p_host_range;
      @(posedge MCLK) disable iff (!RST_N)
      (HOST_LPORT == 3'h0 || HOST_LPORT > count_nxt) |=> !LPORT_VALID;
   endproperty
   a_host_range: assert property (p_host_range) // [RQ6]
      else $error("host port number outside reported range accepted");

   property p_p2_off;
      @(posedge MCLK) disable iff (!RST_N)
      (logical_remap_enable_r && remap_act_r[7:4] == 4'h0)
         |=> !PORT_EN[1] && LOGICAL_P2 == 3'h0;
   endproperty
   a_p2_off: assert property (p_p2_off) // [RQ7]
      else $error("port two not disabled by code zero");

   property p_p2_map;
      @(posedge MCLK) disable iff (!RST_N)
      (logical_remap_enable_r && remap_act_r[7:4] inside {[4'h1:4'h5]})
         |=> LOGICAL_P2 == $past(remap_act_r[6:4]) && PORT_EN[1];
   endproperty
   a_p2_map: assert property (p_p2_map) // [RQ8]
      else $error("port two logical number mismatch");

   property p_p1_map;
      @(posedge MCLK) disable iff (!RST_N)
      (logical_remap_enable_r && remap_act_r[3:0] inside {[4'h1:4'h7]})
         |=> LOGICAL_P1 == $past(remap_act_r[2:0]) && PORT_EN[0];
   endproperty
   a_p1_map: assert property (p_p1_map) // [RQ10]
      else $error("port one logical number mismatch");

   property p_reserved;
      @(posedge MCLK) disable iff (!RST_N)
      (logical_remap_enable_r && remap_act_r[7])
         |=> LOGICAL_P2 == 3'h0 && !PORT_EN[1];
   endproperty
   a_reserved: assert property (p_reserved) // [RQ11]
      else $error("reserved port two code not treated as disable");

   property p_frozen;
      @(posedge MCLK) disable iff (!RST_N)
      lock_r == hub_cfg_pkg::ST_LOCKED
         |=> $stable(swap_act_r) && $stable(remap_act_r)
             && $stable(logical_remap_enable_r);
   endproperty
   a_frozen: assert property (p_frozen) // [RQ12]
      else $error("active settings changed while attached");

   c_up_swap: cover property (@(posedge MCLK) disable iff (!RST_N)
      swap_act_r[0] && CORE_OE[0]);
   c_remap: cover property (@(posedge MCLK) disable iff (!RST_N)
      logical_remap_enable_r && LOGICAL_P2 == 3'h1 && LOGICAL_P1 == 3'h2);
   c_refused: cover property (@(posedge MCLK) disable iff (!RST_N)
      CFG_WR_REFUSED);

endmodule : usb_hub_port_swap_remap_cfg

// ---- design/hub_cfg_pkg.sv ----
// Purpose: shared constants for the hub pin-swap and port-remap block
// Assumes: eight-bit config words, ports 1 and 2 of the remap table only
// Notes:   reset values are plain defaults, software reloads both words

package hub_cfg_pkg;

   // ***********************************************************
   // register map
   // ***********************************************************
   localparam logic [7:0] SWAP_MASK_OFS   = 8'hfa;
   localparam logic [7:0] REMAP12_OFS     = 8'hfb;
   localparam logic [7:0] SWAP_MASK_RST   = 8'h00;
   localparam logic [7:0] REMAP12_RST     = 8'h21;
   localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

   // ***********************************************************
   // field layout
   // ***********************************************************
   localparam int         NUM_PAD_PORTS   = 8;
   localparam int         UPSTREAM_BIT    = 0;
   localparam int         P1_FIELD_LO     = 0;
   localparam int         P2_FIELD_LO     = 4;
   localparam int         NIB_W           = 4;
   localparam int         LPORT_W         = 3;
   localparam logic [3:0] MAX_LPORT_CODE  = 4'h7;
   localparam logic [2:0] LPORT_NONE      = 3'h0;
   localparam logic [2:0] IDENT_P1        = 3'h1;
   localparam logic [2:0] IDENT_P2        = 3'h2;

   // ***********************************************************
   // attach lock
   // ***********************************************************
   typedef enum logic [1:0] {
      ST_OPEN   = 2'b00,
      ST_LOCKED = 2'b01
   } lock_state_t;

   // reserved codes fold to the disable code
   function automatic logic [2:0] nib_to_lport(input logic [3:0] code);
      logic [2:0] res;
      res = (code > MAX_LPORT_CODE) ? LPORT_NONE : code[2:0];
      return res;
   endfunction : nib_to_lport

endpackage : hub_cfg_pkg

// ---- design/port_map_decode.sv ----
// Purpose: decode one remap nibble into a logical port number
// Assumes: identity number is used whenever remapping is off
// Notes:   combinational, the caller registers the result

`timescale 1ns/1ns

module port_map_decode (
   input  wire logic [3:0] code,
   input  wire logic       remap_en,
   input  wire logic [2:0] identity,
   output logic      [2:0] lport,
   output logic            enabled
);

   always_comb begin
      lport   = remap_en ? hub_cfg_pkg::nib_to_lport(code) // [RQ5] [RQ11]
                         : identity;
      enabled = (lport != hub_cfg_pkg::LPORT_NONE);
   end

endmodule : port_map_decode

// ---- testbench/usb_far_side_model.sv ----
// Purpose: far-side port lines of the hub as seen on the board pins
// Assumes: board wiring may cross D+ and D- per port, one bit per port
// Notes:   a pin driven by the hub shows the hub level, never a stale one

`timescale 1ns/1ns

module usb_far_side_model (
   input  wire logic [7:0] wire_swap,
   input  wire logic [7:0] tx_dplus,
   input  wire logic [7:0] tx_dminus,
   input  wire logic [7:0] hub_dp,
   input  wire logic [7:0] hub_dm,
   input  wire logic [7:0] hub_oe,
   output logic      [7:0] pad_dp,
   output logic      [7:0] pad_dm
);
   // ***************
   // wire resolution
   // ***************
   // the hub wins a pin it drives, the far device only fills released pins
   assign pad_dp = (hub_oe & hub_dp)
                 | (~hub_oe & ((tx_dplus & ~wire_swap)
                             | (tx_dminus & wire_swap)));
   assign pad_dm = (hub_oe & hub_dm)
                 | (~hub_oe & ((tx_dminus & ~wire_swap)
                             | (tx_dplus & wire_swap)));
endmodule : usb_far_side_model

// ---- testbench/usb_hub_port_swap_remap_cfg_bench.sv ----
// Purpose: self-checking bench for pin swap, remap, lock and reads
// Assumes: inputs change 1 ns after the rising edge
// Notes:   read data is checked from a queue by a separate monitor

`timescale 1ns/1ns

module usb_hub_port_swap_remap_cfg_bench;
   logic       MCLK, RST_N, CFG_WR, CFG_RD, CFG_WR_REFUSED;
   logic       LOGICAL_REMAP_ENABLE, ATTACH_REQ, ATTACH_LOCKED, LPORT_VALID;
   logic [7:0] CFG_ADDR, CFG_WDATA, CFG_RDATA;
   logic [7:0] CORE_DPLUS_O, CORE_DMINUS_O, CORE_OE;
   logic [7:0] CORE_DPLUS_I, CORE_DMINUS_I, PAD_DP_I, PAD_DM_I;
   logic [7:0] PAD_DP_O, PAD_DM_O, PAD_OE, wire_swap, tx_dp, tx_dm, m, w;
   logic [2:0] LOGICAL_P1, LOGICAL_P2, REPORTED_PORTS, HOST_LPORT, e1, e2;
   logic [1:0] PORT_EN, LPORT_PHYS;
   logic [7:0] rq[$];
   logic       rd_d;
   logic [31:0] seed;
   int         mismatches, checks_done, cyc;

   usb_hub_port_swap_remap_cfg i_dut (.MCLK(MCLK), .RST_N(RST_N),
      .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
      .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
      .CFG_WR_REFUSED(CFG_WR_REFUSED),
      .LOGICAL_REMAP_ENABLE(LOGICAL_REMAP_ENABLE), .ATTACH_REQ(ATTACH_REQ),
      .ATTACH_LOCKED(ATTACH_LOCKED), .CORE_DPLUS_O(CORE_DPLUS_O),
      .CORE_DMINUS_O(CORE_DMINUS_O), .CORE_OE(CORE_OE),
      .CORE_DPLUS_I(CORE_DPLUS_I), .CORE_DMINUS_I(CORE_DMINUS_I),
      .PAD_DP_I(PAD_DP_I), .PAD_DM_I(PAD_DM_I), .PAD_DP_O(PAD_DP_O),
      .PAD_DM_O(PAD_DM_O), .PAD_OE(PAD_OE), .LOGICAL_P1(LOGICAL_P1),
      .LOGICAL_P2(LOGICAL_P2), .PORT_EN(PORT_EN),
      .REPORTED_PORTS(REPORTED_PORTS), .HOST_LPORT(HOST_LPORT),
      .LPORT_VALID(LPORT_VALID), .LPORT_PHYS(LPORT_PHYS));

   usb_far_side_model i_far (.wire_swap(wire_swap), .tx_dplus(tx_dp),
      .tx_dminus(tx_dm), .hub_dp(PAD_DP_O), .hub_dm(PAD_DM_O),
      .hub_oe(PAD_OE), .pad_dp(PAD_DP_I), .pad_dm(PAD_DM_I));

   // ***************
   // helpers
   // ***************
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   // codes above seven fold to the disable code
   function automatic logic [2:0] lp(input logic [3:0] c);
      return (c > 4'h7) ? 3'h0 : c[2:0];
   endfunction : lp

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask : wait_n

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      #1 CFG_WR = 1'b1; CFG_ADDR = a; CFG_WDATA = d;
      @(posedge MCLK);
      #1 CFG_WR = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge MCLK);
      #1 CFG_RD = 1'b1; CFG_ADDR = a; rq.push_back(exp);
      @(posedge MCLK);
      #1 CFG_RD = 1'b0;
   endtask : rd

   // remap outputs, enable bits and count from the two expected numbers
   task automatic chk_map(input logic [2:0] p1, input logic [2:0] p2);
      chk({5'h00, LOGICAL_P1}, {5'h00, p1});
      chk({5'h00, LOGICAL_P2}, {5'h00, p2});
      chk({6'h00, PORT_EN}, {6'h00, (p2 != 3'h0), (p1 != 3'h0)});
      chk({5'h00, REPORTED_PORTS},
          8'((p1 != 3'h0) + (p2 != 3'h0)));
   endtask : chk_map

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   // ***************
   // clock, monitor, timeout
   // ***************
   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end

   // read data stands from the edge after the strobe
   always @(posedge MCLK) begin
      if (rd_d && rq.size() > 0) chk(CFG_RDATA, rq.pop_front());
      rd_d <= CFG_RD;
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         test_done();
      end
   end

   // ***************
   // main sequence
   // ***************
   initial begin
      seed = 32'd90190; rd_d = 1'b0; cyc = 0;
      RST_N = 1'b0; CFG_WR = 1'b0; CFG_RD = 1'b0; CFG_ADDR = 8'h00;
      CFG_WDATA = 8'h00; LOGICAL_REMAP_ENABLE = 1'b0; ATTACH_REQ = 1'b0;
      CORE_DPLUS_O = 8'h00; CORE_DMINUS_O = 8'h00; CORE_OE = 8'h00;
      HOST_LPORT = 3'h0; wire_swap = 8'h00; tx_dp = 8'h00; tx_dm = 8'h00;
      repeat (10) @(posedge MCLK);
      #1 RST_N = 1'b1;
      rd(8'hfa, 8'h00);
      rd(8'hfb, 8'h21);
      rd(8'h10, 8'h00);
      wait_n(2);
      chk_map(3'h1, 3'h2);
      // swap: first mask exercises the upstream bit alone
      for (int i = 0; i < 6; i++) begin
         m = (i == 0) ? 8'h01 : rnd();
         wr(8'hfa, m);
         rd(8'hfa, m);
         CORE_DPLUS_O = rnd(); CORE_DMINUS_O = rnd(); CORE_OE = rnd();
         wait_n(4);
         chk(PAD_DP_O, (CORE_DPLUS_O & ~m) | (CORE_DMINUS_O & m));
         chk(PAD_DM_O, (CORE_DMINUS_O & ~m) | (CORE_DPLUS_O & m));
         chk(PAD_OE, CORE_OE);
         CORE_OE = 8'h00; wire_swap = m; tx_dp = rnd(); tx_dm = rnd();
         wait_n(6);
         chk(CORE_DPLUS_I, tx_dp);
         chk(CORE_DMINUS_I, tx_dm);
      end
      // remap fields ignored while the enable is off
      wr(8'hfb, 8'h00);
      wait_n(4);
      chk_map(3'h1, 3'h2);
      LOGICAL_REMAP_ENABLE = 1'b1;
      for (int c = 0; c < 16; c++) begin
         w = {4'(c), 4'(15 - c)};
         wr(8'hfb, w);
         wait_n(4);
         chk_map(lp(w[3:0]), lp(w[7:4]));
      end
      // contiguous crossed numbering from the config source
      wr(8'hfb, 8'h12);
      wait_n(4);
      for (int h = 0; h < 4; h++) begin
         HOST_LPORT = 3'(h);
         wait_n(1);
         chk({7'h00, LPORT_VALID}, {7'h00, (h == 1 || h == 2)});
         if (h == 1) chk({6'h00, LPORT_PHYS}, 8'h02);
         if (h == 2) chk({6'h00, LPORT_PHYS}, 8'h01);
         if (h == 0 || h == 3) chk({6'h00, LPORT_PHYS}, 8'h00);
      end
      // attached: writes dropped and flagged, outputs frozen
      e1 = 3'h2; e2 = 3'h1;
      ATTACH_REQ = 1'b1;
      wait_n(3);
      chk({7'h00, ATTACH_LOCKED}, 8'h01);
      wr(8'hfb, 8'h34);
      chk({7'h00, CFG_WR_REFUSED}, 8'h01);
      wait_n(1);
      chk({7'h00, CFG_WR_REFUSED}, 8'h00);
      rd(8'hfb, 8'h12);
      LOGICAL_REMAP_ENABLE = 1'b0;
      wait_n(4);
      chk_map(e1, e2);
      ATTACH_REQ = 1'b0;
      wait_n(3);
      chk({7'h00, ATTACH_LOCKED}, 8'h00);
      wr(8'hfb, 8'h34);
      rd(8'hfb, 8'h34);
      wait_n(4);
      chk_map(3'h1, 3'h2);
      test_done();
   end
endmodule : usb_hub_port_swap_remap_cfg_bench
